// file: rtl/power_save_consts.svh
/*
 * Register offsets, field positions, reset values and counts for the
 * power-save and wake control block.
 * Assumes inclusion by bare name from rtl/ and dv/ files.
 */
`ifndef POWER_SAVE_CONSTS_SVH
`define POWER_SAVE_CONSTS_SVH

// Register byte offsets on the register bus
`define OFS_WAKE_CTRL 8'h00
`define OFS_CLOCK_DIV 8'h04
`define OFS_PWR_CMD 8'h08
`define OFS_PWR_STAT 8'h0C
`define OFS_IRQ_FLAGS5 8'h10
`define OFS_PERIPH_DIS 8'h14
`define OFS_PERIPH_EN 8'h18
`define OFS_PERIPH_IDL 8'h1C

// Wake-up unit control fields
`define WAKE_EN_BIT 15
`define WAKE_SIDL_BIT 13
`define WAKE_SINK_BIT 8
`define WAKE_CTRL_MASK 16'hA100
`define WAKE_CTRL_RESET 16'h0000

// Clock divider fields
`define CDIV_ROI_BIT 15
`define CDIV_RATIO_HI 14
`define CDIV_RATIO_LO 12
`define CDIV_SLOW_BIT 11
`define CDIV_MASK 16'hF800
`define CDIV_RESET 16'h0000

// Interrupt flag register five: wake flag
`define WAKE_FLAG_BIT 0

// Power-save command field values
`define CMD_SLEEP_VAL 2'h1
`define CMD_IDLE_VAL 2'h2

// Peripheral count and read value of a disabled block
`define NUM_PERIPH 8
`define PERIPH_INVALID_READ 32'hDEAD_BEEF

`endif

// file: rtl/power_save_pkg.sv
/*
 * Types shared by the power-save and wake control files.
 * Assumes the constants header is included where offsets are needed.
 */
package power_save_pkg;

    // Power state of the core
    typedef enum logic [1:0] {
        RUN,
        ENTERING,
        SLEEP,
        IDLE
    } power_state_e;

    // Selected power-save mode
    typedef enum logic {
        MODE_SLEEP,
        MODE_IDLE
    } save_mode_e;

endpackage : power_save_pkg

// file: rtl/pin_sync.sv
/*
 * Three-stage synchroniser for one pin level; a change is taken once
 * the second and third stages agree.
 * Assumes an asynchronous input and a single system clock.
 */
`timescale 1ns/1ps
`default_nettype none

module pin_sync (
    // Clock, reset, enable
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic clkEn,
    // Pin in, filtered level out
    input wire logic pinIn,
    output logic level
);

    logic [2:0] stage;
    logic [2:0] next_stage;
    logic next_level;

    // Shift in; only stages two and three feed the filter
    always_comb begin
        next_stage = {stage[1:0], pinIn};
        next_level = (stage[1] == stage[2]) ? stage[2] : level;
    end

    // Idle level high: the capacitor is charged before use
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            stage <= 3'h7;
            level <= 1'b1;
        end else if (clkEn) begin
            stage <= next_stage;
            level <= next_level;
        end
    end

endmodule : pin_sync

`default_nettype wire

// file: rtl/cpu_clock_divider.sv
/*
 * Slow-CPU clock-enable generator: one pulse every N system clocks.
 * Assumes the ratio field and slow enable come from the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

module cpu_clock_divider (
    // Clock, reset, enable
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic clkEn,
    // Control
    input wire logic slowActive,
    input wire logic [2:0] ratio,
    // Core clock enable
    output logic cpuTick
);

    logic [6:0] count;
    logic [6:0] next_count;
    logic [6:0] lastCount;

    // Ratio code n divides by 2**n, so 0 gives 1:1 and 7 gives 1:128
    always_comb begin
        lastCount = 7'((8'h01 << ratio) - 8'h01);
        if (!slowActive || count >= lastCount) begin
            next_count = 7'h00;
        end else begin
            next_count = count + 7'h01;
        end
    end

    // Counter runs on the system clock, so both domains share edges
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            count <= 7'h00;
        end else if (clkEn) begin
            count <= next_count;
        end
    end

    // Tick at the end of each period; full speed when not slowed
    assign cpuTick = clkEn && (!slowActive || count >= lastCount); // [RULE19] [RULE9]

    a_tick_spacing: assert property (@(posedge ref_clk) disable iff (reset) // [RULE19]
        (clkEn && slowActive && ratio == 3'h1 && cpuTick) ##1
        (clkEn && slowActive && ratio == 3'h1) |-> !cpuTick)
        else $error("tick repeated within a 1:2 period");

endmodule : cpu_clock_divider

`default_nettype wire

// file: rtl/power_save_wake_control.sv
/*
 * Power-save and wake control: Sleep/Idle entry and wake, wake-up unit
 * on the wake pin, slow-CPU clock enable, per-peripheral gating; all
 * registers reached over AXI4-Lite.
 * Assumes one 100 MHz system clock and a synchronous active-high reset.
 */
`timescale 1ns/1ps
`default_nettype none
`include "power_save_consts.svh"

// How it works
// RULE1 - Interrupt during entry wakes after entry completes
// RULE2 - Wake pin below threshold ends Sleep
// RULE3 - Wake-up ending Sleep sets flag bit 0
// RULE4 - Control bit 15 enables wake-up unit
// RULE5 - Control bit 13 stops unit in Idle
// RULE6 - Control bit 8 drives current sink
// RULE7 - Unused control bits read zero, ignore writes
// RULE8 - Software charges pin, then enables, then sleeps
// RULE9 - Slow mode slows only the CPU clock
// RULE10 - CPU and peripheral domains stay edge-synchronised
// RULE11 - Divider bit 11 enables slow mode
// RULE12 - Bits 14:12 pick ratio 1:1 to 1:128
// RULE13 - Divider bit 15 makes interrupts restore speed
// RULE14 - Disable bit gates clocks and registers
// RULE15 - Function enable stops function, keeps registers
// RULE16 - Stop-in-Idle bit disables peripheral in Idle
// RULE17 - Command selects Sleep or Idle
// RULE18 - Interrupt, watchdog or reset ends power save
// RULE19 - CPU clock is enable every N cycles
// RULE20 - Detection only when enabled and not idled
module power_save_wake_control
    import power_save_pkg::*;
(
    // Clock, reset, enable
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic clkEn,
    // AXI4-Lite write
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Core events
    input wire logic intPending,
    input wire logic watchdogTimeout,
    // Wake pin
    input wire logic wakePin,
    output logic wakeSinkOn,
    // Clock enables out
    output logic cpuClkEn,
    output logic [7:0] periphClkEn,
    output logic [7:0] periphRun,
    output logic [7:0] periphRegAccess,
    output logic wakeEvent
);

    ////////////////////////////////////////////////////////////////////
    // Registers and state

    logic [15:0] wakeCtrl, next_wakeCtrl, clockDiv, next_clockDiv;
    logic [7:0] periphDis, next_periphDis, periphEn, next_periphEn, periphIdl, next_periphIdl;
    logic wakeFlag, next_wakeFlag, heldInt, next_heldInt, slowActive, next_slowActive;
    power_state_e state, next_state;
    save_mode_e mode, next_mode;
    logic pinLevel, pinLevelD, next_pinLevelD, wakeDetect, cmdWrite, cpuTick;
    logic [1:0] cmdVal, bResp, next_bResp, rResp, next_rResp;
    // AXI state
    logic awHeld, next_awHeld, wHeld, next_wHeld, bValid, next_bValid, rValid, next_rValid;
    logic [7:0] awAddr, next_awAddr;
    logic [31:0] wData, next_wData, rData, next_rData, readMux;
    logic [3:0] wStrb, next_wStrb;
    logic doWrite, doRead, readOk, writeOk;

    ////////////////////////////////////////////////////////////////////
    // Helpers

    pin_sync u_pin_sync (
        .ref_clk(ref_clk),
        .reset(reset),
        .clkEn(clkEn),
        .pinIn(wakePin),
        .level(pinLevel)
    );

    cpu_clock_divider u_div (
        .ref_clk(ref_clk),
        .reset(reset),
        .clkEn(clkEn),
        .slowActive(slowActive),
        .ratio(clockDiv[`CDIV_RATIO_HI:`CDIV_RATIO_LO]),
        .cpuTick(cpuTick)
    );

    ////////////////////////////////////////////////////////////////////
    // AXI4-Lite slave: address and data taken in either order

    assign s_axi_awready = !awHeld && !bValid;
    assign s_axi_wready = !wHeld && !bValid;
    assign s_axi_arready = !rValid;
    assign s_axi_bvalid = bValid;
    assign s_axi_bresp = bResp;
    assign s_axi_rvalid = rValid;
    assign s_axi_rdata = rData;
    assign s_axi_rresp = rResp;

    // Write fires once both halves are held
    assign doWrite = awHeld && wHeld && !bValid;
    assign doRead = s_axi_arvalid && s_axi_arready;
    assign cmdWrite = doWrite && awAddr == `OFS_PWR_CMD && wStrb[0];
    assign cmdVal = wData[1:0];

    // Known-address decode; unmapped answers SLVERR
    assign writeOk = awAddr inside {`OFS_WAKE_CTRL, `OFS_CLOCK_DIV, `OFS_PWR_CMD,
        `OFS_IRQ_FLAGS5, `OFS_PERIPH_DIS, `OFS_PERIPH_EN, `OFS_PERIPH_IDL};

    // Read mux; unused bits come back zero
    always_comb begin
        readOk = 1'b1;
        unique case (s_axi_araddr)
            `OFS_WAKE_CTRL: readMux = {16'h0000, wakeCtrl}; // [RULE7]
            `OFS_CLOCK_DIV: readMux = {16'h0000, clockDiv};
            `OFS_PWR_CMD: readMux = 32'h0000_0000;
            `OFS_PWR_STAT: readMux = {28'h000_0000, slowActive, pinLevel, state};
            `OFS_IRQ_FLAGS5: readMux = {31'h0000_0000, wakeFlag};
            `OFS_PERIPH_DIS: readMux = {24'h00_0000, periphDis};
            `OFS_PERIPH_EN: readMux = {24'h00_0000, periphEn};
            `OFS_PERIPH_IDL: readMux = {24'h00_0000, periphIdl};
            default: begin
                readMux = 32'h0000_0000;
                readOk = 1'b0;
            end
        endcase
    end

    // Bus next-state
    always_comb begin
        {next_awHeld, next_wHeld, next_awAddr, next_wData, next_wStrb} =
            {awHeld, wHeld, awAddr, wData, wStrb};
        {next_bValid, next_bResp, next_rValid, next_rData, next_rResp} =
            {bValid, bResp, rValid, rData, rResp};
        if (s_axi_awvalid && s_axi_awready) begin
            next_awHeld = 1'b1;
            next_awAddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_wHeld = 1'b1;
            next_wData = s_axi_wdata;
            next_wStrb = s_axi_wstrb;
        end
        if (doWrite) begin
            next_awHeld = 1'b0;
            next_wHeld = 1'b0;
            next_bValid = 1'b1;
            next_bResp = writeOk ? 2'b00 : 2'b10;
        end else if (bValid && s_axi_bready) begin
            next_bValid = 1'b0;
        end
        if (doRead) begin
            next_rValid = 1'b1;
            next_rData = readMux;
            next_rResp = readOk ? 2'b00 : 2'b10;
        end else if (rValid && s_axi_rready) begin
            next_rValid = 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            {awHeld, wHeld, bValid, rValid} <= 4'h0;
            {awAddr, wData, wStrb, bResp, rData, rResp} <= 80'h0;
        end else if (clkEn) begin
            {awHeld, wHeld, bValid, rValid} <=
                {next_awHeld, next_wHeld, next_bValid, next_rValid};
            {awAddr, wData, wStrb, bResp, rData, rResp} <=
                {next_awAddr, next_wData, next_wStrb, next_bResp, next_rData, next_rResp};
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Control registers and wake-up unit

    // Falling crossing of the threshold while enabled and not idled
    assign wakeDetect = wakeCtrl[`WAKE_EN_BIT] && pinLevelD && !pinLevel // [RULE20] [RULE4]
        && !(state == IDLE && wakeCtrl[`WAKE_SIDL_BIT]); // [RULE5]
    assign wakeEvent = wakeDetect && state == SLEEP;
    assign wakeSinkOn = wakeCtrl[`WAKE_SINK_BIT]; // [RULE6]

    always_comb begin
        next_wakeCtrl = wakeCtrl;
        next_clockDiv = clockDiv;
        next_wakeFlag = wakeFlag;
        next_periphDis = periphDis;
        next_periphEn = periphEn;
        next_periphIdl = periphIdl;
        next_pinLevelD = pinLevel;
        if (doWrite && wStrb[1:0] != 2'b00) begin
            unique case (awAddr)
                `OFS_WAKE_CTRL: next_wakeCtrl = wData[15:0] & `WAKE_CTRL_MASK; // [RULE7]
                `OFS_CLOCK_DIV: next_clockDiv = wData[15:0] & `CDIV_MASK; // [RULE12]
                `OFS_IRQ_FLAGS5: next_wakeFlag = wData[`WAKE_FLAG_BIT];
                `OFS_PERIPH_DIS: next_periphDis = wData[7:0];
                `OFS_PERIPH_EN: next_periphEn = wData[7:0];
                `OFS_PERIPH_IDL: next_periphIdl = wData[7:0];
                default: ;
            endcase
        end
        // Set beats a simultaneous software clear
        if (wakeEvent) begin
            next_wakeFlag = 1'b1; // [RULE3]
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            {wakeCtrl, clockDiv, wakeFlag} <= {`WAKE_CTRL_RESET, `CDIV_RESET, 1'b0};
            {periphDis, periphEn, periphIdl, pinLevelD} <= {8'h00, 8'hFF, 8'h00, 1'b1};
        end else if (clkEn) begin
            {wakeCtrl, clockDiv, wakeFlag} <= {next_wakeCtrl, next_clockDiv, next_wakeFlag};
            {periphDis, periphEn, periphIdl, pinLevelD} <=
                {next_periphDis, next_periphEn, next_periphIdl, next_pinLevelD};
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Power state machine

    always_comb begin
        next_state = state;
        next_mode = mode;
        next_heldInt = heldInt;
        unique case (state)
            RUN: begin
                if (cmdWrite && (cmdVal == `CMD_SLEEP_VAL || cmdVal == `CMD_IDLE_VAL)) begin
                    next_state = ENTERING; // [RULE17]
                    next_mode = (cmdVal == `CMD_SLEEP_VAL) ? MODE_SLEEP : MODE_IDLE;
                    next_heldInt = intPending;
                end
            end
            ENTERING: begin
                // Interrupts here are held, not lost
                next_heldInt = heldInt || intPending;
                next_state = (mode == MODE_SLEEP) ? SLEEP : IDLE; // [RULE1]
            end
            SLEEP, IDLE: begin
                next_heldInt = 1'b0;
                if (heldInt || intPending || watchdogTimeout || wakeEvent) begin
                    next_state = RUN; // [RULE18] [RULE1] [RULE2]
                end
            end
        endcase
    end

    // Slow mode set by the enable bit, dropped on interrupt when asked
    always_comb begin
        next_slowActive = clockDiv[`CDIV_SLOW_BIT] // [RULE11]
            && !(clockDiv[`CDIV_ROI_BIT] && intPending); // [RULE13]
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state <= RUN;
            mode <= MODE_SLEEP;
            heldInt <= 1'b0;
            slowActive <= 1'b0;
        end else if (clkEn) begin
            state <= next_state;
            mode <= next_mode;
            heldInt <= next_heldInt;
            slowActive <= next_slowActive;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Clock enables

    // CPU ticks only while running, from the shared system clock
    assign cpuClkEn = cpuTick && state == RUN; // [RULE10] [RULE9]

    for (genvar p = 0; p < `NUM_PERIPH; p++) begin : g_periph
        assign periphClkEn[p] = clkEn && !periphDis[p] && state != SLEEP // [RULE14]
            && !(state == IDLE && periphIdl[p]); // [RULE16]
        assign periphRun[p] = periphClkEn[p] && periphEn[p]; // [RULE15]
        assign periphRegAccess[p] = !periphDis[p]; // [RULE14] [RULE15]
    end

    ////////////////////////////////////////////////////////////////////
    // Checks

    sequence s_sleep_and_fall;
        state == SLEEP && wakeDetect && clkEn;
    endsequence

    a_wake_exit: assert property (@(posedge ref_clk) disable iff (reset) // [RULE2]
        s_sleep_and_fall |=> state == RUN)
        else $error("pin fall in Sleep did not wake");
    a_wake_flag: assert property (@(posedge ref_clk) disable iff (reset) // [RULE3]
        s_sleep_and_fall |=> wakeFlag)
        else $error("wake flag not set");
    a_held_int: assert property (@(posedge ref_clk) disable iff (reset) // [RULE1]
        state == ENTERING && intPending && clkEn |=> state != RUN ##1 1)
        else $error("entry aborted by interrupt");
    a_ctrl_zero: assert property (@(posedge ref_clk) disable iff (reset) // [RULE7]
        (wakeCtrl & ~`WAKE_CTRL_MASK) == 16'h0000)
        else $error("unused control bits set");
    a_sink_bit: assert property (@(posedge ref_clk) disable iff (reset) // [RULE6]
        wakeSinkOn == wakeCtrl[`WAKE_SINK_BIT])
        else $error("sink not following bit");
    a_sleep_cpu: assert property (@(posedge ref_clk) disable iff (reset) // [RULE17]
        state != RUN |-> !cpuClkEn && (state != SLEEP || periphClkEn == 8'h00))
        else $error("clocks running in power save");
    a_no_detect_off: assert property (@(posedge ref_clk) disable iff (reset) // [RULE20]
        !wakeCtrl[`WAKE_EN_BIT] |-> !wakeDetect)
        else $error("detection while unit disabled");
    a_roi_exit: assert property (@(posedge ref_clk) disable iff (reset) // [RULE13]
        slowActive && clockDiv[`CDIV_ROI_BIT] && intPending && clkEn |=> !slowActive)
        else $error("interrupt did not restore speed");
    a_idle_stop: assert property (@(posedge ref_clk) disable iff (reset) // [RULE16]
        state == IDLE |-> (periphClkEn & periphIdl) == 8'h00)
        else $error("idle-stopped block clocked");

endmodule : power_save_wake_control

`default_nettype wire

// file: dv/rc_wake_pin_model.sv
/*
 * Behavioural capacitor and series resistor on the wake pin.
 * Assumes the bench drives the charge strobe and the block drives the sink.
 */
`timescale 1ns/1ps
`default_nettype none

module rc_wake_pin_model (
    // Clock
    input wire logic ref_clk,
    // Charge from port driver, discharge from current sink
    input wire logic chargeOn,
    input wire logic sinkOn,
    // Pin level seen by the digital input
    output logic pinLevel
);
    int unsigned volts = 0;

    // Charge sets full at once; the sink removes one step per cycle, a slow ramp so the sync sees a clean edge
    always @(posedge ref_clk) begin
        if (chargeOn) begin
            volts <= 100;
        end else if (sinkOn && volts > 0) begin
            volts <= volts - 1;
        end
    end

    // Input-low threshold at forty percent of full charge
    assign pinLevel = (volts > 40);
endmodule : rc_wake_pin_model

`default_nettype wire

// file: dv/power_save_wake_control_tb.sv
/*
 * Self-checking bench for the power-save and wake control block.
 * Assumes the AXI4-Lite slave answers in a few cycles and a 100 MHz clock.
 */
`timescale 1ns/1ps
`default_nettype none
`include "power_save_consts.svh"

module power_save_wake_control_tb
    import power_save_pkg::*;
;
    logic ref_clk = 1'h0;
    logic reset = 1'h1;
    logic clkEn = 1'h1;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic intPending = 1'h0, watchdogTimeout = 1'h0, chargeOn = 1'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, lastResp;
    logic [31:0] s_axi_rdata, rdVal;
    logic wakePin, wakeSinkOn, cpuClkEn, wakeEvent;
    logic [7:0] periphClkEn, periphRun, periphRegAccess;
    int error_cnt = 0;
    int comparisons = 0;
    int seed = 32'h5991;
    int hits;

    always #5 ref_clk = ~ref_clk;

    power_save_wake_control power_save_wake_control_inst (
        .ref_clk, .reset, .clkEn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .intPending,
        .watchdogTimeout, .wakePin, .wakeSinkOn, .cpuClkEn, .periphClkEn,
        .periphRun, .periphRegAccess, .wakeEvent
    );

    rc_wake_pin_model rc_wake_pin_model_inst (
        .ref_clk, .chargeOn, .sinkOn(wakeSinkOn), .pinLevel(wakePin)
    );

    ////////////////////////////////////////////////////////////////////////
    // Expectations
    function automatic logic [31:0] exp_wake(input logic [31:0] d);
        return {16'h0000, d[15:0] & `WAKE_CTRL_MASK};
    endfunction : exp_wake

    // Any window that is a multiple of the period holds window/period pulses
    function automatic int exp_ticks(input int window, input int r);
        return window >> r;
    endfunction : exp_ticks

    ////////////////////////////////////////////////////////////////////////
    // Compare, bus and event tasks
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    // Each channel held until its ready is seen at a rising edge
    task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(posedge ref_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (!s_axi_bvalid);
        lastResp = s_axi_bresp;
        s_axi_bready <= 1'h0;
    endtask : bus_write

    task automatic bus_read(input logic [7:0] a);
        @(posedge ref_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do begin
            @(posedge ref_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (!s_axi_rvalid);
        rdVal = s_axi_rdata;
        lastResp = s_axi_rresp;
        s_axi_rready <= 1'h0;
    endtask : bus_read

    // Counts cycles with cpuClkEn (sel 0) or wakeEvent (sel 1) high
    task automatic count_high(input logic sel, input int n);
        hits = 0;
        repeat (n) begin
            @(posedge ref_clk);
            if ((sel ? wakeEvent : cpuClkEn) === 1'h1) hits++;
        end
    endtask : count_high

    task automatic pulse_event(input logic wd);
        @(posedge ref_clk);
        if (wd) watchdogTimeout <= 1'h1;
        else intPending <= 1'h1;
        @(posedge ref_clk);
        watchdogTimeout <= 1'h0;
        intPending <= 1'h0;
        repeat (3) @(posedge ref_clk);
    endtask : pulse_event

    // Charge, stop charging, arm the unit, then Sleep
    task automatic wake_try(input logic [31:0] ctrl, input int expWake);
        @(posedge ref_clk);
        chargeOn <= 1'h1;
        repeat (100) @(posedge ref_clk);
        chargeOn <= 1'h0;
        bus_write(`OFS_WAKE_CTRL, ctrl);
        bus_write(`OFS_PWR_CMD, {30'h0, `CMD_SLEEP_VAL});
        count_high(1'h1, 300);
        check("wake pulses", expWake, hits);
        if (expWake == 0) pulse_event(1'h0);
        bus_read(`OFS_IRQ_FLAGS5);
        check("wake flag", expWake, {31'h0, rdVal[`WAKE_FLAG_BIT]});
        bus_read(`OFS_PWR_STAT);
        check("state after wake", {30'h0, RUN}, {30'h0, rdVal[1:0]});
        bus_write(`OFS_IRQ_FLAGS5, 32'h0000_0000);
        bus_write(`OFS_WAKE_CTRL, 32'h0000_0000);
    endtask : wake_try

    task automatic close_out();
        $display("Mismatches %0d, comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : close_out

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        logic [31:0] d;
        repeat (20) @(posedge ref_clk);
        reset <= 1'h0;
        bus_read(`OFS_WAKE_CTRL);
        check("wake ctrl reset", 32'h0000_0000, rdVal);
        bus_read(`OFS_CLOCK_DIV);
        check("divider reset", 32'h0000_0000, rdVal);
        bus_read(8'h40);
        check("unmapped resp", 32'h0000_0002, {30'h0, lastResp});
        // Full word first, then random words
        for (int i = 0; i < 6; i++) begin
            d = (i == 0) ? 32'h0000_FFFF : $random(seed);
            bus_write(`OFS_WAKE_CTRL, d);
            check("write resp", 32'h0000_0000, {30'h0, lastResp});
            bus_read(`OFS_WAKE_CTRL);
            check("wake ctrl", exp_wake(d), rdVal);
            check("sink", {31'h0, d[8]}, {31'h0, wakeSinkOn});
        end
        bus_write(`OFS_WAKE_CTRL, 32'h0000_0000);
        // Every ratio, then ratio set with slow mode off
        for (int r = 0; r < 8; r++) begin
            bus_write(`OFS_CLOCK_DIV, 32'h0000_0800 | (r << 12));
            count_high(1'h0, 128);
            check("cpu ticks", exp_ticks(128, r), hits);
            check("periph clocks", 32'h0000_00FF, {24'h0, periphClkEn});
        end
        bus_write(`OFS_CLOCK_DIV, 32'h0000_7000);
        count_high(1'h0, 128);
        check("slow off ticks", 128, hits);
        // Recover on interrupt set, then clear
        for (int k = 0; k < 2; k++) begin
            bus_write(`OFS_CLOCK_DIV, k ? 32'h0000_7800 : 32'h0000_F800);
            @(posedge ref_clk);
            intPending <= 1'h1;
            repeat (2) @(posedge ref_clk);
            count_high(1'h0, 128);
            check("roi ticks", k ? 1 : 128, hits);
            intPending <= 1'h0;
        end
        bus_write(`OFS_CLOCK_DIV, 32'h0000_0000);
        // Sleep, then wake on interrupt
        bus_write(`OFS_PWR_CMD, {30'h0, `CMD_SLEEP_VAL});
        repeat (4) @(posedge ref_clk);
        count_high(1'h0, 8);
        check("sleep ticks", 0, hits);
        pulse_event(1'h0);
        count_high(1'h0, 8);
        check("woken ticks", 8, hits);
        // Interrupt already pending while the command is taken
        @(posedge ref_clk);
        intPending <= 1'h1;
        bus_write(`OFS_PWR_CMD, {30'h0, `CMD_SLEEP_VAL});
        intPending <= 1'h0;
        repeat (4) @(posedge ref_clk);
        bus_read(`OFS_PWR_STAT);
        check("coincident wake", {30'h0, RUN}, {30'h0, rdVal[1:0]});
        // Module disable, function off, stop in Idle
        bus_write(`OFS_PERIPH_DIS, 32'h0000_0002);
        bus_write(`OFS_PERIPH_EN, 32'h0000_00FB);
        bus_write(`OFS_PERIPH_IDL, 32'h0000_0009);
        check("reg access", 32'h0000_00FD, {24'h0, periphRegAccess});
        check("module clocks", 32'h0000_00FD, {24'h0, periphClkEn});
        check("periph run", 32'h0000_00F9, {24'h0, periphRun});
        bus_write(`OFS_PWR_CMD, {30'h0, `CMD_IDLE_VAL});
        repeat (4) @(posedge ref_clk);
        count_high(1'h0, 8);
        check("idle ticks", 0, hits);
        check("idle run", 32'h0000_00F0, {24'h0, periphRun});
        pulse_event(1'h1);
        count_high(1'h0, 8);
        check("watchdog wake", 8, hits);
        bus_write(`OFS_PERIPH_DIS, 32'h0000_0000);
        bus_write(`OFS_PERIPH_EN, 32'h0000_00FF);
        bus_write(`OFS_PERIPH_IDL, 32'h0000_0000);
        // Sink only leaves the unit deaf; enabled unit wakes
        wake_try(32'h0000_0100, 0);
        wake_try(32'h0000_8100, 1);
        close_out();
    end

    // Whole run is a few thousand cycles; ten times that means a hang
    initial begin
        repeat (30000) @(posedge ref_clk);
        error_cnt++;
        close_out();
    end
endmodule : power_save_wake_control_tb

`default_nettype wire
